// ### design/gtimer_pkg.sv
// Package with register map, field layout, modes and bus carriers of the timer channel.
package gtimer_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 24;
  localparam int PRE_W = 21;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CONTROL_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT_READBACK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LOAD_VALUE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_VALUE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PRESCALER_PRELOAD = 8'h10;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CSR_RST = 24'h00_0000;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h00_0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hFF_FFFF;
  localparam logic [PRE_W-1:0] PRE_RST = 21'h00_0000;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // Bit positions of the write-one-to-clear flags.
  localparam int OVF_FLAG_POS = 16;
  localparam int CMP_FLAG_POS = 17;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_GPIO = 4'h0,
    MODE_PULSE = 4'h1,
    MODE_TOGGLE = 4'h2,
    MODE_EVENT = 4'h3,
    MODE_WIDTH = 4'h4,
    MODE_PERIOD = 4'h5,
    MODE_CAPTURE = 4'h6,
    MODE_PWM = 4'h7,
    MODE_WD_PULSE = 4'h9,
    MODE_WD_TOGGLE = 4'hA
  } mode_t;

  // Gray sequence along idle, arm, run; halt only after a capture.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_RUN = 2'b11,
    ST_HALT = 2'b10
  } chan_state_t;

  // Layout of control_status, most significant field first.
  typedef struct packed {
    logic [5:0] rsvdHigh;
    logic compareFlag;
    logic overflowFlag;
    logic [2:0] rsvdMid;
    logic gpioData;
    logic gpioDir;
    logic prescalerSel;
    logic reloadOnMatch;
    logic polarityInvert;
    mode_t modeField;
    logic rsvdLow;
    logic compareIrqEnable;
    logic overflowIrqEnable;
    logic channelEnable;
  } csr_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic overflowReq;
    logic compareReq;
  } irq_t;

endpackage

// ### design/prescaler_tick.sv
// Shared prescaler that divides the core clock into a one-cycle tick.
`timescale 1ns/1ps
`default_nettype none
module prescaler_tick (
  input wire logic core_clk, // Core clock.
  input wire logic rst_n, // Synchronised reset, active low.
  input wire logic [gtimer_pkg::PRE_W-1:0] preloadVal, // Divide ratio minus one.
  output logic tick // One-cycle tick per prescaler period.
);
  import gtimer_pkg::*;

  logic [PRE_W-1:0] count_ff;

  // A new preload takes effect at the next wrap, so a running period is never cut short.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= PRE_RST;
      tick <= 1'b0;
    end else if (count_ff == PRE_RST) begin
      count_ff <= preloadVal;
      tick <= 1'b1;
    end else begin
      count_ff <= count_ff - 21'h00_0001;
      tick <= 1'b0;
    end
  end
endmodule // prescaler_tick
`default_nettype wire

// ### design/pin_edge_sync.sv
// Synchroniser and polarity-selected edge detector for the timer pin.
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
  input wire logic core_clk, // Core clock.
  input wire logic rst_n, // Synchronised reset, active low.
  input wire logic pinIn, // Raw pin level.
  input wire logic fallSel, // High selects falling edges.
  output logic syncLevel, // Synchronised pin level.
  output logic edgeSeen // One-cycle pulse on the selected edge.
);
  logic meta_ff;
  logic prev_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      syncLevel <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pinIn;
      syncLevel <= meta_ff;
      prev_ff <= syncLevel;
    end
  end

  assign edgeSeen = fallSel ? (prev_ff & ~syncLevel) : (~prev_ff & syncLevel);
endmodule // pin_edge_sync
`default_nettype wire

// ### design/general_timer_channel_24b.sv
// One 24-bit timer and event-counter channel with its APB register file.
//
// Notes on behaviour
// - Five registers: 24-bit status, count, load, compare; 21-bit prescaler preload.
// - Hardware or software reset clears control_status.
// - Counts only while enable bit 0 set.
// - Mode field sits in bits 7 to 4.
// - Mode codes 0-7, 9, 10 as listed.
// - Setting enable clears counter; clearing stops.
// - First timer clock (with pin edge in 4-6) loads the load value.
// - Overflow sets flag; interrupt when enabled.
// - Overflow flag clears by one-write or service.
// - Compare flag clears by one-write or service.
// - Overflow outranks compare when both pending.
// - Compare on match, or pin edge in 4-6.
// - Count readback never disturbs the count.
// - Mode 0: flag on match, optional reload.
// - Mode 1: pin inverted one clock on match.
// - Mode 2: pin toggles on every match.
// - Mode 3 counts synchronised events below quarter rate.
// - Polarity bit picks falling or rising edges.
// - Shared 21-bit prescaler offers alternative clock.
`timescale 1ns/1ps
`default_nettype none
module general_timer_channel_24b (
  input wire logic core_clk, // Core clock, 100 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire gtimer_pkg::apb_req_t apbReq, // APB request from the master.
  output gtimer_pkg::apb_rsp_t apbRsp, // APB answer to the master.
  input wire logic softResetReq, // Software reset instruction pulse.
  input wire logic overflowAck, // Overflow exception serviced pulse.
  input wire logic compareAck, // Compare exception serviced pulse.
  input wire logic timerPinIn, // Timer pin level seen from outside.
  output logic timerPinOut, // Level driven on the timer pin.
  output logic timerPinOe, // High while the channel drives the pin.
  output gtimer_pkg::irq_t irq // Interrupt requests, overflow first.
);
  import gtimer_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta_ff;
  logic rst_n;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rst_n <= rstMeta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  csr_t csr_ff;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] loadValue_ff;
  logic [CNT_W-1:0] compareValue_ff;
  logic [PRE_W-1:0] prescalerPreload_ff;
  chan_state_t state_ff;
  chan_state_t nxt_state;
  logic reloadPending_ff;
  logic pulseActive_ff;
  logic toggleLevel_ff;
  logic enablePrev_ff;
  logic preTick;
  logic pinLevel;
  logic pinEdge;
  logic apbWrite;
  logic apbAccess;
  logic addrHit;
  logic enableRise;
  logic timerTick;
  logic measureMode;
  logic matchEvent;
  logic overflowEvent;
  logic [CNT_W-1:0] nxt_count;
  logic [CNT_W-1:0] wdata24;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    is_mapped = (addr == OFS_CONTROL_STATUS) || (addr == OFS_COUNT_READBACK) ||
                (addr == OFS_LOAD_VALUE) || (addr == OFS_COMPARE_VALUE) ||
                (addr == OFS_PRESCALER_PRELOAD);
  endfunction

  function automatic logic drives_pin(input mode_t m);
    drives_pin = (m == MODE_PULSE) || (m == MODE_TOGGLE);
  endfunction

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  prescaler_tick u_prescaler (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .preloadVal(prescalerPreload_ff),
    .tick(preTick)
  );

  // The pin is sampled through two flops, so external events must stay slow.
  pin_edge_sync u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(timerPinIn),
    .fallSel(csr_ff.polarityInvert),
    .syncLevel(pinLevel),
    .edgeSeen(pinEdge)
  );

  assign measureMode = (csr_ff.modeField == MODE_WIDTH) ||
                       (csr_ff.modeField == MODE_PERIOD) ||
                       (csr_ff.modeField == MODE_CAPTURE);

  // Event mode counts pin edges unless the prescaler is chosen.
  always_comb begin
    if (csr_ff.modeField == MODE_EVENT) begin
      timerTick = csr_ff.prescalerSel ? preTick : pinEdge;
    end else begin
      timerTick = csr_ff.prescalerSel ? preTick : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ----------------------------------------------------------------
  assign apbAccess = apbReq.psel & apbReq.penable & apbRsp.pready;
  assign apbWrite = apbAccess & apbReq.pwrite & addrHit;
  assign addrHit = is_mapped(apbReq.paddr);
  assign wdata24 = apbReq.pwdata[CNT_W-1:0];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready <= apbReq.psel & apbReq.penable & ~apbRsp.pready;
      apbRsp.pslverr <= apbReq.psel & apbReq.penable & ~apbRsp.pready & ~addrHit;
      apbRsp.prdata <= RDATA_ZERO;
      if (apbReq.psel & apbReq.penable & ~apbRsp.pready & ~apbReq.pwrite) begin
        case (apbReq.paddr)
          OFS_CONTROL_STATUS: apbRsp.prdata <= {8'h00, csr_ff};
          OFS_COUNT_READBACK: apbRsp.prdata <= {8'h00, count_ff};
          OFS_COMPARE_VALUE: apbRsp.prdata <= {8'h00, compareValue_ff};
          OFS_PRESCALER_PRELOAD: apbRsp.prdata <= {11'h000, prescalerPreload_ff};
          default: apbRsp.prdata <= RDATA_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Value registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loadValue_ff <= CNT_RST;
      compareValue_ff <= CNT_RST;
      prescalerPreload_ff <= PRE_RST;
    end else if (apbWrite) begin
      case (apbReq.paddr)
        OFS_LOAD_VALUE: loadValue_ff <= wdata24;
        OFS_COMPARE_VALUE: compareValue_ff <= wdata24;
        OFS_PRESCALER_PRELOAD: prescalerPreload_ff <= apbReq.pwdata[PRE_W-1:0];
        default: loadValue_ff <= loadValue_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control and status
  // ----------------------------------------------------------------
  // Hardware events win over a clear arriving in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      csr_ff <= CSR_RST;
    end else if (softResetReq) begin
      csr_ff <= CSR_RST;
    end else begin
      if (apbWrite && apbReq.paddr == OFS_CONTROL_STATUS) begin
        csr_ff.channelEnable <= wdata24[0];
        csr_ff.overflowIrqEnable <= wdata24[1];
        csr_ff.compareIrqEnable <= wdata24[2];
        csr_ff.modeField <= mode_t'(wdata24[7:4]);
        csr_ff.polarityInvert <= wdata24[8];
        csr_ff.reloadOnMatch <= wdata24[9];
        csr_ff.prescalerSel <= wdata24[10];
        csr_ff.gpioDir <= wdata24[11];
        csr_ff.gpioData <= wdata24[12];
        if (wdata24[OVF_FLAG_POS]) begin
          csr_ff.overflowFlag <= 1'b0;
        end
        if (wdata24[CMP_FLAG_POS]) begin
          csr_ff.compareFlag <= 1'b0;
        end
      end
      if (overflowAck) begin
        csr_ff.overflowFlag <= 1'b0;
      end
      if (compareAck) begin
        csr_ff.compareFlag <= 1'b0;
      end
      if (overflowEvent) begin
        csr_ff.overflowFlag <= 1'b1;
      end
      if (matchEvent) begin
        csr_ff.compareFlag <= 1'b1;
      end
      if (csr_ff.modeField == MODE_GPIO && !csr_ff.gpioDir) begin
        csr_ff.gpioData <= pinLevel;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel sequencing
  // ----------------------------------------------------------------
  assign enableRise = csr_ff.channelEnable & ~enablePrev_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = csr_ff.channelEnable ? ST_ARM : ST_IDLE;
      ST_ARM: begin
        if (!csr_ff.channelEnable) begin
          nxt_state = ST_IDLE;
        end else if (timerTick && (!measureMode || pinEdge)) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!csr_ff.channelEnable) begin
          nxt_state = ST_IDLE;
        end else if (csr_ff.modeField == MODE_CAPTURE && pinEdge) begin
          nxt_state = ST_HALT;
        end
      end
      ST_HALT: nxt_state = csr_ff.channelEnable ? ST_HALT : ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Measurement modes wait for the selected pin edge before loading.
  assign matchEvent = (state_ff == ST_RUN) &&
                      (measureMode ? pinEdge : (timerTick && !reloadPending_ff &&
                                                nxt_count == compareValue_ff));
  assign overflowEvent = (state_ff == ST_RUN) && timerTick && !reloadPending_ff &&
                         (count_ff == CNT_MAX);
  assign nxt_count = count_ff + 24'h00_0001;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      enablePrev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      enablePrev_ff <= csr_ff.channelEnable;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= CNT_RST;
      reloadPending_ff <= 1'b0;
    end else if (enableRise) begin
      count_ff <= CNT_RST;
      reloadPending_ff <= 1'b0;
    end else if (state_ff == ST_ARM && nxt_state == ST_RUN) begin
      count_ff <= loadValue_ff;
    end else if (state_ff == ST_RUN && timerTick) begin
      if (reloadPending_ff) begin
        count_ff <= loadValue_ff;
        reloadPending_ff <= 1'b0;
      end else if (!(csr_ff.modeField == MODE_CAPTURE && pinEdge)) begin
        count_ff <= nxt_count;
        reloadPending_ff <= matchEvent & csr_ff.reloadOnMatch & ~measureMode;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer pin
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulseActive_ff <= 1'b0;
      toggleLevel_ff <= 1'b0;
    end else if (enableRise || state_ff == ST_IDLE) begin
      pulseActive_ff <= 1'b0;
      toggleLevel_ff <= 1'b0;
    end else if (matchEvent && csr_ff.modeField == MODE_PULSE) begin
      pulseActive_ff <= 1'b1;
    end else if (matchEvent && csr_ff.modeField == MODE_TOGGLE) begin
      toggleLevel_ff <= ~toggleLevel_ff;
    end else if (timerTick) begin
      pulseActive_ff <= 1'b0;
    end
  end

  // Output mux is registered so the pin never glitches during a mode decode.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerPinOut <= 1'b0;
      timerPinOe <= 1'b0;
    end else if (drives_pin(csr_ff.modeField) && csr_ff.channelEnable) begin
      timerPinOe <= 1'b1;
      timerPinOut <= csr_ff.polarityInvert ^ pulseActive_ff ^ toggleLevel_ff;
    end else begin
      timerPinOe <= (csr_ff.modeField == MODE_GPIO) & csr_ff.gpioDir;
      timerPinOut <= csr_ff.gpioData;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= '0;
    end else begin
      irq.overflowReq <= csr_ff.overflowFlag & csr_ff.overflowIrqEnable;
      irq.compareReq <= csr_ff.compareFlag & csr_ff.compareIrqEnable &
                        ~(csr_ff.overflowFlag & csr_ff.overflowIrqEnable);
    end
  end
endmodule // general_timer_channel_24b
`default_nettype wire

// ### testbench/gtimer_properties.sv
// Port-level timing properties of the timer channel.
`timescale 1ns/1ps
`default_nettype none
module gtimer_properties (
  input wire logic core_clk, // Core clock.
  input wire logic arst_n, // Reset, active low.
  input wire gtimer_pkg::apb_req_t apbReq, // APB request.
  input wire gtimer_pkg::apb_rsp_t apbRsp, // APB answer.
  input wire logic softResetReq, // Software reset pulse.
  input wire logic overflowAck, // Overflow serviced.
  input wire logic compareAck, // Compare serviced.
  input wire logic timerPinIn, // Pin level in.
  input wire logic timerPinOut, // Pin level out.
  input wire logic timerPinOe, // Pin drive enable.
  input wire gtimer_pkg::irq_t irq // Interrupt requests.
);
  import gtimer_pkg::*;
  logic mapped;
  assign mapped = apbReq.paddr inside {OFS_CONTROL_STATUS, OFS_COUNT_READBACK,
    OFS_LOAD_VALUE, OFS_COMPARE_VALUE, OFS_PRESCALER_PRELOAD};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  sequence setupPh;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence accessPh;
    apbReq.psel && apbReq.penable;
  endsequence
  a_one_wait_state: assert property (setupPh ##1 accessPh |-> !apbRsp.pready ##1 apbRsp.pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (apbRsp.pready |-> accessPh)
    else $error("pready outside an access");
  a_hole_error: assert property (apbRsp.pready |-> apbRsp.pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_rdata_quiet: assert property (!apbRsp.pready || apbRsp.pslverr |-> apbRsp.prdata == RDATA_ZERO)
    else $error("prdata not zero");
  a_word_width: assert property (apbRsp.pready |-> apbRsp.prdata[31:24] == 8'h00)
    else $error("prdata above 24 bits");
  a_load_reads_zero: assert property (apbRsp.pready && apbReq.paddr == OFS_LOAD_VALUE |->
    apbRsp.prdata == RDATA_ZERO)
    else $error("load value readable");
  a_irq_order: assert property (irq.compareReq |-> !irq.overflowReq)
    else $error("compare request beside overflow request");
  a_ovf_service: assert property (overflowAck |-> ##[1:2] !irq.overflowReq)
    else $error("overflow request stays after service");
  a_cmp_service: assert property (compareAck |-> ##[1:2] !irq.compareReq)
    else $error("compare request stays after service");
  a_soft_clear: assert property (softResetReq |-> ##[1:3] (irq == '0 && !timerPinOe))
    else $error("soft reset left channel active");
endmodule // gtimer_properties
`default_nettype wire

// ### testbench/pin_event_source.sv
// Event source that toggles the timer pin in bursts.
`timescale 1ns/1ps
`default_nettype none
module pin_event_source (
  input wire logic core_clk, // Core clock.
  input wire logic park, // Move the line to restLvl.
  input wire logic restLvl, // Level taken on park.
  input wire logic go, // Start a burst.
  input wire logic [7:0] nToggle, // Toggles in the burst.
  output logic pinLvl, // Level driven on the pin.
  output logic busy // High during a burst.
);
  logic [7:0] left = 8'h00;
  logic [1:0] gap = 2'h0;
  initial pinLvl = 1'b0;
  assign busy = (left != 8'h00);
  // A toggle every third cycle keeps events well under a quarter of the core rate.
  always @(posedge core_clk) begin
    if (park) begin
      pinLvl <= restLvl;
    end else if (go) begin
      left <= nToggle;
      gap <= 2'h2;
    end else if (left != 8'h00) begin
      if (gap == 2'h0) begin
        pinLvl <= ~pinLvl;
        left <= left - 8'h01;
        gap <= 2'h2;
      end else begin
        gap <= gap - 2'h1;
      end
    end
  end
endmodule // pin_event_source
`default_nettype wire

// ### testbench/tb_general_timer_channel_24b.sv
// Self-checking bench for the 24-bit timer channel.
`timescale 1ns/1ps
`default_nettype none
module tb_general_timer_channel_24b;
  import gtimer_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, softResetReq = 1'b0, overflowAck = 1'b0;
  logic compareAck = 1'b0, park = 1'b0, restLvl = 1'b0, go = 1'b0;
  logic timerPinOut, timerPinOe, pinWire, srcLvl, busy, polarity_invert;
  logic [7:0] nToggle = 8'h00;
  logic [23:0] ld;
  apb_req_t apbReq = '0;
  apb_rsp_t apbRsp;
  irq_t irq;
  logic [64:0] notes[$];
  logic [64:0] note;
  logic [3:0] modes[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA};
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int n, g, k;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] NOPIN = 32'hFFFF_EFFF;

  general_timer_channel_24b uut (.core_clk(core_clk), .arst_n(arst_n), .apbReq(apbReq),
    .apbRsp(apbRsp), .softResetReq(softResetReq), .overflowAck(overflowAck),
    .compareAck(compareAck), .timerPinIn(pinWire), .timerPinOut(timerPinOut),
    .timerPinOe(timerPinOe), .irq(irq));
  pin_event_source src (.core_clk(core_clk), .park(park), .restLvl(restLvl), .go(go),
    .nToggle(nToggle), .pinLvl(srcLvl), .busy(busy));
  // The pin is the channel's while it drives, otherwise the source's.
  assign pinWire = timerPinOe ? timerPinOut : srcLvl;
  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Bus master, answer watcher and helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] cfg(input logic [3:0] m, input logic [1:0] rt,
      input logic [2:0] ie);
    return {22'h00_0000, rt, m, 1'b0, ie};
  endfunction
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic [31:0] msk);
    notes.push_back({!(a inside {OFS_CONTROL_STATUS, OFS_COUNT_READBACK, OFS_LOAD_VALUE,
      OFS_COMPARE_VALUE, OFS_PRESCALER_PRELOAD}), msk, e});
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (apbRsp.pready !== 1'b1);
    apbReq <= '0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0000_0000, 32'h0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] msk);
    xfer(1'b0, a, 32'h0000_0000, e, msk);
  endtask
  always @(posedge core_clk) begin
    if (apbRsp.pready === 1'b1) begin
      note = notes.pop_front();
      num_checks++;
      if (apbRsp.pslverr !== note[64] || ((apbRsp.prdata ^ note[31:0]) & note[63:32]) !== 0) begin
        n_mismatch++;
        $display("Error at %0t: read %h expected %h", $time, apbRsp.prdata, note[31:0]);
      end
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    num_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic gap(output int c);
    logic was;
    was = pinWire;
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (pinWire === was && c < 100);
  endtask
  task automatic await_irq(input logic ovf);
    k = 0;
    while ((ovf ? irq.overflowReq : irq.compareReq) !== 1'b1 && k < 100) begin
      @(posedge core_clk);
      k++;
    end
    @(posedge core_clk);
  endtask
  task automatic burst(input logic [7:0] t);
    nToggle <= t;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (2) @(posedge core_clk);
    k = 0;
    while (busy && k < 300) begin
      @(posedge core_clk);
      k++;
    end
    repeat (8) @(posedge core_clk);
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0 && notes.size() == 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'he5b0_d187));
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(OFS_CONTROL_STATUS, 32'h0000_0000, NOPIN);
    rd(OFS_LOAD_VALUE, 32'h0000_0000, ALL);
    wr(OFS_COUNT_READBACK, 32'h0000_1234);
    rd(OFS_COUNT_READBACK, 32'h0000_0000, ALL);
    rd(8'h14, 32'h0000_0000, ALL);
    foreach (modes[i]) begin
      wr(OFS_CONTROL_STATUS, cfg(modes[i], 2'b00, 3'b000));
      rd(OFS_CONTROL_STATUS, cfg(modes[i], 2'b00, 3'b000), NOPIN);
    end
    wr(OFS_CONTROL_STATUS, cfg(4'h2, 2'b11, 3'b110));
    softResetReq <= 1'b1;
    @(posedge core_clk);
    softResetReq <= 1'b0;
    @(posedge core_clk);
    rd(OFS_CONTROL_STATUS, 32'h0000_0000, NOPIN);
    ld = 24'hFF_FFF0 + 24'($urandom % 8);
    wr(OFS_LOAD_VALUE, {8'h00, ld});
    wr(OFS_COMPARE_VALUE, {8'h00, ld + 24'h00_0004});
    wr(OFS_CONTROL_STATUS, cfg(4'h0, 2'b00, 3'b110));
    wr(OFS_CONTROL_STATUS, cfg(4'h0, 2'b00, 3'b111));
    await_irq(1'b0);
    chk(irq.compareReq, 1'b1);
    await_irq(1'b1);
    chk(irq.compareReq, 1'b0);
    rd(OFS_CONTROL_STATUS, cfg(4'h0, 2'b00, 3'b111) | 32'h0003_0000, NOPIN);
    overflowAck <= 1'b1;
    @(posedge core_clk);
    overflowAck <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(irq.overflowReq, 1'b0);
    chk(irq.compareReq, 1'b1);
    wr(OFS_CONTROL_STATUS, cfg(4'h0, 2'b00, 3'b111) | 32'h0002_0000);
    @(posedge core_clk);
    chk(irq.compareReq, 1'b0);
    compareAck <= 1'b1;
    @(posedge core_clk);
    compareAck <= 1'b0;
    rd(OFS_CONTROL_STATUS, cfg(4'h0, 2'b00, 3'b111), NOPIN);
    wr(OFS_CONTROL_STATUS, 32'h0000_0000);
    for (int m = 1; m < 3; m++) begin
      polarity_invert = 1'($urandom);
      ld = 24'($urandom % 64);
      wr(OFS_LOAD_VALUE, {8'h00, ld});
      wr(OFS_COMPARE_VALUE, {8'h00, ld + 24'h00_000A});
      wr(OFS_CONTROL_STATUS, cfg(4'(m), {1'b1, polarity_invert}, 3'b000));
      wr(OFS_CONTROL_STATUS, cfg(4'(m), {1'b1, polarity_invert}, 3'b001));
      repeat (2) @(posedge core_clk);
      chk(timerPinOe, 1'b1);
      chk(pinWire, polarity_invert);
      gap(g);
      gap(g);
      chk(g, m == 1 ? 1 : 11);
      gap(g);
      chk(g, m == 1 ? 10 : 11);
      wr(OFS_CONTROL_STATUS, 32'h0000_0000);
    end
    for (int v = 0; v < 2; v++) begin
      polarity_invert = v[0];
      ld = 24'($urandom % 4096);
      n = 2 + $urandom % 6;
      restLvl <= polarity_invert;
      park <= 1'b1;
      @(posedge core_clk);
      park <= 1'b0;
      wr(OFS_LOAD_VALUE, {8'h00, ld});
      wr(OFS_COMPARE_VALUE, 32'h0080_0000);
      wr(OFS_CONTROL_STATUS, cfg(4'h3, {1'b0, polarity_invert}, 3'b000));
      wr(OFS_CONTROL_STATUS, cfg(4'h3, {1'b0, polarity_invert}, 3'b001));
      burst(8'(2 * n + 1));
      rd(OFS_COUNT_READBACK, {8'h00, ld + 24'(n)}, ALL);
      wr(OFS_CONTROL_STATUS, cfg(4'h3, {1'b0, polarity_invert}, 3'b000));
      burst(8'h02);
      rd(OFS_COUNT_READBACK, {8'h00, ld + 24'(n)}, ALL);
    end
    test_done();
  end
endmodule // tb_general_timer_channel_24b

bind general_timer_channel_24b gtimer_properties chk_i (.core_clk(core_clk), .arst_n(arst_n),
  .apbReq(apbReq), .apbRsp(apbRsp), .softResetReq(softResetReq), .overflowAck(overflowAck),
  .compareAck(compareAck), .timerPinIn(timerPinIn), .timerPinOut(timerPinOut),
  .timerPinOe(timerPinOe), .irq(irq));
`default_nettype wire
